// File: design/ftr_report_tail.sv
// What this block does
// R1: Health byte leads the tail; bit 0 set on antenna feed fault.
// R2: Health bit 1 shows shorted antenna; sent only alongside bit 0.
// R3: Health bit 2 marks 2-D fix, sent only when status code is zero.
// R4: Health bit 3 marks augmented fix, sent only when status code is zero.
// R5: Health bit 4 set when battery-backed memory was unusable at power-up.
// R6: Health bit 5 set when real-time clock was missing at power-up.
// R7: Health bit 6 set while almanac is incomplete or stale.
// R8: Health bit 7 set while measurement clock bias is unknown.
// R9: Byte after health byte is reserved and always zero.
// R10: Each record starts with satellite id, 1 to 32 or 120 to 138.
// R11: Record byte 1 is signal strength, 0 to 55 dB-Hz.
// R12: Record bytes 2-3 hold acquisition flags, bits 0 to 3 meaningful.
// R13: Acquisition flag bits above 3 are reserved and sent as zero.
// R14: Record bytes 4-7 hold unsigned pseudo range in centimetres.
// R15: Record bytes 8-11 hold signed range rate in mm/s.
// R16: Twelve records follow, one per channel, in channel order.
// R17: Host forms time as milliseconds times one million plus sub_ms_time_ns.
// R18: Host trusts sub_ms_time_ns only while health bit 7 is clear.
// R19: Status code zero means fixing; other codes mean no valid fix.
// R20: Multi-byte fields go out most significant byte first.
module ftr_report_tail #(
	parameter int NUM_CH  = ftr_pkg::NUM_CH,
	parameter int FRAME_W = 16
) (
	input  wire logic                    clk,
	input  wire logic                    sys_rst,
	input  wire logic                    ce,
	input  wire logic [ftr_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [31:0]             bus_wdata,
	input  wire logic                    bus_wr,
	input  wire logic                    bus_rd,
	output      logic [31:0]             bus_rdata,
	input  wire ftr_pkg::ftr_health_in_s health_in,
	input  wire logic [7:0]              rcv_status,
	input  wire logic                    tx_ready,
	output      logic [7:0]              tx_data,
	output      logic                    tx_valid,
	output      logic                    tx_last
);
	localparam int MEM_DEPTH = NUM_CH * ftr_pkg::REC_WORDS;
	localparam int MEM_AW    = $clog2(MEM_DEPTH);
	localparam int CH_W      = $clog2(NUM_CH);
	localparam logic [CH_W-1:0]   LAST_CH    = CH_W'(NUM_CH - 1);
	localparam logic [1:0]        LAST_WORD  = 2'(ftr_pkg::REC_WORDS - 1);
	localparam logic [MEM_AW-1:0] WORDS_AW   = MEM_AW'(ftr_pkg::REC_WORDS);

	function automatic logic sid_ok(input logic [7:0] sid);
		sid_ok = (sid >= ftr_pkg::SID_NAV_MIN && sid <= ftr_pkg::SID_NAV_MAX) ||
			(sid >= ftr_pkg::SID_AUG_MIN && sid <= ftr_pkg::SID_AUG_MAX);
	endfunction

	ftr_pkg::ftr_state_e st_q;
	ftr_pkg::ftr_state_e st_d;
	logic [7:0]          tx_data_q;
	logic                tx_valid_q;
	logic                tx_last_q;
	logic [23:0]         shift_q;
	logic [1:0]          byte_q;
	logic [1:0]          word_q;
	logic [CH_W-1:0]     ch_q;
	logic                pwr_done_q;
	logic                bbm_q;
	logic                rtc_q;
	logic                err_q;
	logic [FRAME_W-1:0]  frames_q;
	logic [31:0]         rdata_q;
	logic [31:0]         mem_rdata;
	logic [7:0]          health_d;
	logic [31:0]         rec_word;
	logic [31:0]         rdata_d;

	// Register decode
	wire       sel_ctrl   = bus_addr == ftr_pkg::REG_CTRL;
	wire       sel_stat   = bus_addr == ftr_pkg::REG_STAT;
	wire       sel_frames = bus_addr == ftr_pkg::REG_FRAMES;
	wire [5:0] ch_widx    = bus_addr[7:2] - ftr_pkg::CH_BASE_IDX;
	wire       sel_chan   = (bus_addr >= ftr_pkg::CH_BASE) && (32'(ch_widx) < MEM_DEPTH);
	wire       is_word0   = (32'(ch_widx) % ftr_pkg::REC_WORDS) == 0;
	wire       sid_bad    = is_word0 && !sid_ok(bus_wdata[31:24]); // R10
	wire       chan_we    = bus_wr && sel_chan && !sid_bad; // R10
	wire       bad_id_set = ce && bus_wr && sel_chan && sid_bad;
	wire       clr_err    = bus_wr && sel_ctrl && bus_wdata[ftr_pkg::CTRL_CLR];
	wire       busy       = st_q != ftr_pkg::FTR_IDLE;
	wire       start_go   = ce && bus_wr && sel_ctrl && bus_wdata[ftr_pkg::CTRL_START] && !busy;

	// Link handshake and sequencing
	wire adv       = tx_valid_q && tx_ready;
	wire last_word = (ch_q == LAST_CH) && (word_q == LAST_WORD);
	wire rec_done  = adv && (byte_q == ftr_pkg::LAST_BYTE);
	wire frame_end = (st_q == ftr_pkg::FTR_SEND) && rec_done && last_word;
	wire fixing    = rcv_status == ftr_pkg::STATUS_FIX; // R19

	// Health byte assembly
	assign health_d[ftr_pkg::HB_FAULT] = health_in.ant_fault; // R1
	assign health_d[ftr_pkg::HB_SHORT] = health_in.ant_short && health_in.ant_fault; // R2
	assign health_d[ftr_pkg::HB_FIX2D] = health_in.fix_2d && fixing; // R3
	assign health_d[ftr_pkg::HB_AUG]   = health_in.aug_fix && fixing; // R4
	assign health_d[ftr_pkg::HB_BBM]   = bbm_q; // R5
	assign health_d[ftr_pkg::HB_RTC]   = rtc_q; // R6
	assign health_d[ftr_pkg::HB_ALM]   = health_in.alm_stale; // R7
	assign health_d[ftr_pkg::HB_BIAS]  = health_in.bias_unknown; // R8

	// Record word shaping: strength clamp and reserved flag bits
	wire [7:0]  cn0_raw = mem_rdata[23:16];
	wire [7:0]  cn0_lim = (cn0_raw > ftr_pkg::MAX_CN0) ? ftr_pkg::MAX_CN0 : cn0_raw; // R11
	wire [15:0] acq     = mem_rdata[15:0] & ftr_pkg::ACQ_MASK; // R12 R13
	assign rec_word = (word_q == 2'h0) ? {mem_rdata[31:24], cn0_lim, acq} : mem_rdata; // R14 R15

	wire [MEM_AW-1:0] rd_idx = MEM_AW'(ch_q) * WORDS_AW + MEM_AW'(word_q); // R10 R16

	ftr_chan_mem #(
		.WIDTH (32),
		.DEPTH (MEM_DEPTH),
		.AW    (MEM_AW)
	) u_mem (
		.clk     (clk),
		.ce      (ce),
		.we      (chan_we),
		.waddr   (ch_widx[MEM_AW-1:0]),
		.wdata   (bus_wdata),
		.re      (st_q == ftr_pkg::FTR_FETCH),
		.raddr   (rd_idx),
		.rdata_q (mem_rdata)
	);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ftr_pkg::FTR_IDLE: begin
				if (start_go) begin
					st_d = ftr_pkg::FTR_HEALTH;
				end
			end
			ftr_pkg::FTR_HEALTH: begin
				if (adv) begin
					st_d = ftr_pkg::FTR_RSVD;
				end
			end
			ftr_pkg::FTR_RSVD: begin
				if (adv) begin
					st_d = ftr_pkg::FTR_FETCH;
				end
			end
			ftr_pkg::FTR_FETCH: st_d = ftr_pkg::FTR_LOAD;
			ftr_pkg::FTR_LOAD:  st_d = ftr_pkg::FTR_SEND;
			ftr_pkg::FTR_SEND: begin
				if (rec_done) begin
					st_d = last_word ? ftr_pkg::FTR_IDLE : ftr_pkg::FTR_FETCH; // R16
				end
			end
			default: st_d = ftr_pkg::FTR_IDLE;
		endcase
	end

	// Outgoing byte register, most significant byte first
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q       <= ftr_pkg::FTR_IDLE;
			tx_data_q  <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_last_q  <= 1'b0;
			shift_q    <= 24'h000000;
			byte_q     <= 2'h0;
		end else if (ce) begin
			st_q <= st_d;
			unique case (st_q)
				ftr_pkg::FTR_IDLE: begin
					if (start_go) begin
						tx_data_q  <= health_d; // R1
						tx_valid_q <= 1'b1;
					end
				end
				ftr_pkg::FTR_HEALTH: begin
					if (adv) begin
						tx_data_q <= ftr_pkg::RSVD_BYTE; // R9
					end
				end
				ftr_pkg::FTR_RSVD: begin
					if (adv) begin
						tx_valid_q <= 1'b0;
					end
				end
				ftr_pkg::FTR_LOAD: begin
					tx_data_q  <= rec_word[31:24]; // R20
					shift_q    <= rec_word[23:0];
					byte_q     <= 2'h0;
					tx_valid_q <= 1'b1;
				end
				ftr_pkg::FTR_SEND: begin
					if (rec_done) begin
						tx_valid_q <= 1'b0;
						tx_last_q  <= 1'b0;
					end else if (adv) begin
						tx_data_q <= shift_q[23:16]; // R20
						shift_q   <= {shift_q[15:0], 8'h00};
						byte_q    <= byte_q + 2'h1;
						tx_last_q <= last_word && (byte_q == ftr_pkg::LAST_BYTE - 2'h1);
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Channel and word position within the record area
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ch_q   <= '0;
			word_q <= 2'h0;
		end else if (ce) begin
			if (start_go) begin
				ch_q   <= '0;
				word_q <= 2'h0;
			end else if (st_q == ftr_pkg::FTR_SEND && rec_done && !last_word) begin
				word_q <= (word_q == LAST_WORD) ? 2'h0 : word_q + 2'h1; // R16
				ch_q   <= (word_q == LAST_WORD) ? ch_q + CH_W'(1) : ch_q; // R16
			end
		end
	end

	// Power-up conditions are caught once after reset release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwr_done_q <= 1'b0;
			bbm_q      <= 1'b0;
			rtc_q      <= 1'b0;
		end else if (ce && !pwr_done_q) begin
			pwr_done_q <= 1'b1;
			bbm_q      <= health_in.battery_backed_memory_fail; // R5
			rtc_q      <= health_in.rtc_fail; // R6
		end
	end

	// Software state: sticky id error (set beats clear), frame count, read data
	assign rdata_d = sel_stat ? {14'h0000, err_q, busy, rcv_status, health_d} :
		sel_frames ? 32'(frames_q) : 32'h00000000;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			err_q    <= 1'b0;
			frames_q <= '0;
			rdata_q  <= 32'h00000000;
		end else if (ce) begin
			if (bad_id_set) begin
				err_q <= 1'b1;
			end else if (clr_err) begin
				err_q <= 1'b0;
			end
			if (frame_end) begin
				frames_q <= frames_q + FRAME_W'(1);
			end
			rdata_q <= bus_rd ? rdata_d : 32'h00000000;
		end
	end

	assign tx_data   = tx_data_q;
	assign tx_valid  = tx_valid_q;
	assign tx_last   = tx_last_q;
	assign bus_rdata = rdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_fault_bit;
		start_go |=> tx_data_q[ftr_pkg::HB_FAULT] == $past(health_in.ant_fault);
	endproperty
	a_fault_bit: assert property (p_fault_bit) else $error("fault bit wrong"); // R1

	property p_short_gated;
		st_q == ftr_pkg::FTR_HEALTH |-> !(tx_data_q[ftr_pkg::HB_SHORT] && !tx_data_q[ftr_pkg::HB_FAULT]);
	endproperty
	a_short_gated: assert property (p_short_gated) else $error("short bit w/o fault"); // R2

	property p_fix2d_gated;
		start_go && !fixing |=> !tx_data_q[ftr_pkg::HB_FIX2D];
	endproperty
	a_fix2d_gated: assert property (p_fix2d_gated) else $error("2-D bit without fix"); // R3

	property p_aug_gated;
		start_go && !fixing |=> !tx_data_q[ftr_pkg::HB_AUG];
	endproperty
	a_aug_gated: assert property (p_aug_gated) else $error("aug bit without fix"); // R4

	property p_rsvd_zero;
		st_q == ftr_pkg::FTR_RSVD |-> tx_valid_q && tx_data_q == ftr_pkg::RSVD_BYTE;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte not zero"); // R9

	property p_sid_valid;
		st_q == ftr_pkg::FTR_SEND && word_q == 2'h0 && byte_q == 2'h0 |-> sid_ok(tx_data_q);
	endproperty
	a_sid_valid: assert property (p_sid_valid) else $error("bad satellite id sent"); // R10

	property p_cn0_range;
		st_q == ftr_pkg::FTR_SEND && word_q == 2'h0 && byte_q == 2'h1 |-> tx_data_q <= ftr_pkg::MAX_CN0;
	endproperty
	a_cn0_range: assert property (p_cn0_range) else $error("strength over limit"); // R11

	property p_acq_rsvd;
		st_q == ftr_pkg::FTR_SEND && word_q == 2'h0 && byte_q == 2'h2 |-> tx_data_q == 8'h00;
	endproperty
	a_acq_rsvd: assert property (p_acq_rsvd) else $error("reserved flags set"); // R13

	property p_fetch_load;
		ce && st_q == ftr_pkg::FTR_FETCH ##1 ce [*2] |-> st_q == ftr_pkg::FTR_SEND && tx_valid_q;
	endproperty
	a_fetch_load: assert property (p_fetch_load) else $error("record load late"); // R14 R15

	property p_last_pos;
		tx_last_q |-> ch_q == LAST_CH && word_q == LAST_WORD && byte_q == ftr_pkg::LAST_BYTE;
	endproperty
	a_last_pos: assert property (p_last_pos) else $error("last flag misplaced"); // R16

	property p_hold;
		tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q);
	endproperty
	a_hold: assert property (p_hold) else $error("byte dropped under stall"); // R20

	c_start: cover property (start_go);
	c_frame_end: cover property (frame_end);
	c_stall: cover property (tx_valid_q && !tx_ready ##1 tx_valid_q && tx_ready);
	c_bad_id: cover property (bad_id_set);
endmodule // ftr_report_tail

// File: design/ftr_chan_mem.sv
package ftr_pkg;
	localparam int          NUM_CH      = 12;
	localparam int          REC_WORDS   = 3;
	localparam int          ADDR_W      = 8;
	localparam logic [1:0]  LAST_BYTE   = 2'h3;
	localparam logic [7:0]  RSVD_BYTE   = 8'h00;
	localparam logic [7:0]  STATUS_FIX  = 8'h00;
	localparam logic [7:0]  MAX_CN0     = 8'h37;
	localparam logic [7:0]  SID_NAV_MIN = 8'h01;
	localparam logic [7:0]  SID_NAV_MAX = 8'h20;
	localparam logic [7:0]  SID_AUG_MIN = 8'h78;
	localparam logic [7:0]  SID_AUG_MAX = 8'h8A;
	localparam logic [15:0] ACQ_MASK    = 16'h000F;
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STAT    = 8'h04;
	localparam logic [7:0]  REG_FRAMES  = 8'h08;
	localparam logic [7:0]  CH_BASE     = 8'h40;
	localparam logic [5:0]  CH_BASE_IDX = 6'h10;
	localparam int          CTRL_START  = 0;
	localparam int          CTRL_CLR    = 1;
	localparam int          HB_FAULT    = 0;
	localparam int          HB_SHORT    = 1;
	localparam int          HB_FIX2D    = 2;
	localparam int          HB_AUG      = 3;
	localparam int          HB_BBM      = 4;
	localparam int          HB_RTC      = 5;
	localparam int          HB_ALM      = 6;
	localparam int          HB_BIAS     = 7;

	// Health sources, most significant field is health bit 7
	typedef struct packed {
		logic bias_unknown;
		logic alm_stale;
		logic rtc_fail;
		logic battery_backed_memory_fail;
		logic aug_fix;
		logic fix_2d;
		logic ant_short;
		logic ant_fault;
	} ftr_health_in_s;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} ftr_bus_req_s;

	typedef enum logic [2:0] {
		FTR_IDLE   = 3'h0,
		FTR_HEALTH = 3'h1,
		FTR_RSVD   = 3'h3,
		FTR_FETCH  = 3'h2,
		FTR_LOAD   = 3'h6,
		FTR_SEND   = 3'h7
	} ftr_state_e;
endpackage

module ftr_chan_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 36,
	parameter int AW    = 6
) (
	input  wire logic             clk,
	input  wire logic             ce,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             re,
	input  wire logic [AW-1:0]    raddr,
	output      logic [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
		if (ce && re) begin
			rdata_q <= mem[raddr];
		end
	end
endmodule // ftr_chan_mem

// File: tb/ftr_host_model.sv
// Host side of the byte link: stalls on request, keeps every accepted byte
module ftr_host_model (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       ce,
	input  wire logic       stall,
	input  wire logic       clr,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	input  wire logic       tx_last,
	output      logic       tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [0:199];
	logic       lst [0:199];
	int         n    = 0;
	logic [1:0] ph_q = 2'h0;
	// A byte counts only on an edge the block itself takes
	wire        take = ce && tx_valid && tx_ready;
	// Sub-millisecond time is usable only while the clock bias is known
	wire        time_trusted = (n > 0) && !got[0][ftr_pkg::HB_BIAS];
	// Full measurement time in nanoseconds
	function automatic longint meas_time_ns(input int unsigned ms, input int sub_ms_time_ns);
		return longint'(ms) * 64'd1000000 + longint'(sub_ms_time_ns);
	endfunction
	always @(posedge clk) begin
		ph_q     <= ph_q + 2'h1;
		tx_ready <= !stall || (ph_q == 2'h3);
		if (sys_rst || clr) begin
			n <= 0;
		end else if (take) begin
			got[n] <= tx_data;
			lst[n] <= tx_last;
			n      <= n + 1;
		end
	end
endmodule // ftr_host_model

// File: tb/ftr_report_tail_tb.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (b)); end end
module ftr_report_tail_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    clk        = 1'b0;
	logic                    sys_rst    = 1'b1;
	logic                    ce         = 1'b1;
	logic                    bus_wr     = 1'b0;
	logic                    bus_rd     = 1'b0;
	logic [7:0]              bus_addr   = 8'h00;
	logic [7:0]              rcv_status = 8'h00;
	logic [31:0]             bus_wdata  = 32'h0;
	logic [31:0]             bus_rdata;
	ftr_pkg::ftr_health_in_s health_in  = 8'h30;
	logic                    stall      = 1'b0;
	logic                    clr        = 1'b0;
	logic                    tx_ready;
	logic                    tx_valid;
	logic                    tx_last;
	logic [7:0]              tx_data;
	int                      err_count  = 0;
	int                      n_checks   = 0;
	logic [31:0]             rec [0:35];
	logic [7:0]              exp_b [0:145];
	logic [31:0]             d;
	always #25 clk = ~clk;
	ftr_report_tail dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.health_in(health_in), .rcv_status(rcv_status), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last));
	ftr_host_model host (.clk(clk), .sys_rst(sys_rst), .ce(ce), .stall(stall), .clr(clr),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
	task automatic give_verdict();
		$display("errors %0d checks %0d", err_count, n_checks);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= v;
		@(posedge clk);
		bus_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd   <= 1'b0;
		#1 v = bus_rdata;
	endtask
	function automatic logic [7:0] health_exp(input logic [7:0] h, input logic [7:0] st);
		logic [7:0] e;
		e = h;
		if (!e[0]) e[1] = 1'b0;
		if (st != ftr_pkg::STATUS_FIX) e[3:2] = 2'h0;
		return e;
	endfunction
	// Whole tail: start, watch busy, collect 146 bytes, compare every one
	task automatic frame(input logic [7:0] h, input bit freeze, input logic [15:0] frames);
		int   b;
		int   t;
		logic [7:0] s;
		exp_b[0] = h;
		exp_b[1] = ftr_pkg::RSVD_BYTE;
		for (int c = 0; c < 12; c++) begin
			b = 2 + 12 * c;
			s = rec[3*c][23:16];
			exp_b[b]   = rec[3*c][31:24];
			exp_b[b+1] = (s > ftr_pkg::MAX_CN0) ? ftr_pkg::MAX_CN0 : s;
			exp_b[b+2] = 8'h00;
			exp_b[b+3] = {4'h0, rec[3*c][3:0]};
			for (int k = 0; k < 4; k++) begin
				exp_b[b+4+k] = rec[3*c+1][31-8*k -: 8];
				exp_b[b+8+k] = rec[3*c+2][31-8*k -: 8];
			end
		end
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wr(ftr_pkg::REG_CTRL, 32'h1);
		rd(ftr_pkg::REG_STAT, d);
		`CHK(d[16], 1'b1)
		for (t = 0; t < 3000 && host.n < 146; t++) begin
			@(posedge clk);
			if (freeze && t == 30) ce <= 1'b0;
			if (t == 36) ce <= 1'b1;
		end
		if (t >= 3000) begin
			err_count++;
			give_verdict();
		end
		repeat (4) @(posedge clk);
		#1;
		`CHK(host.n, 146)
		`CHK(tx_valid, 1'b0)
		`CHK(host.got[0], h)
		`CHK(host.got[1], 8'h00)
		for (int i = 2; i < 146; i++) begin
			`CHK(host.got[i], exp_b[i])
		end
		for (int i = 0; i < 146; i++) begin
			`CHK(host.lst[i], (i == 145))
		end
		`CHK(host.time_trusted, !h[ftr_pkg::HB_BIAS])
		rd(ftr_pkg::REG_STAT, d);
		`CHK(d[16], 1'b0)
		rd(ftr_pkg::REG_FRAMES, d);
		`CHK(d[15:0], frames)
	endtask
	// Every health source set, fixing, host stalling
	task automatic sc_all_health();
		health_in  <= 8'hFF;
		rcv_status <= ftr_pkg::STATUS_FIX;
		stall      <= 1'b1;
		frame(8'hFF, 1'b0, 16'h0001);
		stall      <= 1'b0;
	endtask
	// Bad ids refused and flagged; other reads give zero
	task automatic sc_bad_id();
		logic [7:0] ids [4] = '{8'h00, 8'h21, 8'h77, 8'h8B};
		// Power-up flags stay latched when the live sources drop
		health_in <= 8'h00;
		rd(ftr_pkg::REG_STAT, d);
		`CHK(d[7:0], 8'h30)
		foreach (ids[i]) begin
			wr(ftr_pkg::CH_BASE, {ids[i], 24'h0});
			rd(ftr_pkg::REG_STAT, d);
			`CHK(d[17], 1'b1)
			wr(ftr_pkg::REG_CTRL, 32'h2);
			rd(ftr_pkg::REG_STAT, d);
			`CHK(d[17], 1'b0)
		end
		rd(ftr_pkg::REG_CTRL, d);
		`CHK(d, 32'h0)
		rd(ftr_pkg::CH_BASE, d);
		`CHK(d, 32'h0)
		rd(8'h20, d);
		`CHK(d, 32'h0)
	endtask
	// Dependent bits masked for seven non-fixing codes; frame with a ce pause
	task automatic sc_masked();
		logic [7:0] codes [7] = '{8'h01, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'hBB};
		health_in <= 8'hBE;
		foreach (codes[i]) begin
			rcv_status <= codes[i];
			rd(ftr_pkg::REG_STAT, d);
			`CHK(d[15:0], {codes[i], health_exp(8'hBE, codes[i])})
		end
		frame(health_exp(8'hBE, 8'hBB), 1'b1, 16'h0002);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		`CHK(tx_valid, 1'b0)
		`CHK(tx_last, 1'b0)
		`CHK(host.meas_time_ns(32'd7, -250), 64'd6999750)
		for (int c = 0; c < 12; c++) begin
			rec[3*c]   = {(c == 0) ? 8'h01 : (c == 1) ? 8'h20 : (c == 2) ? 8'h78 :
				(c == 3) ? 8'h8A : 8'(c + 4),
				(c == 11) ? 8'h38 : (c == 10) ? 8'h37 : 8'(c * 5), 16'hA5F0 | 16'(c)};
			rec[3*c+1] = 32'h80706050 + 32'(c);
			rec[3*c+2] = -32'(c + 1);
		end
		for (int i = 0; i < 36; i++) begin
			wr(8'(ftr_pkg::CH_BASE + 8'(4 * i)), rec[i]);
		end
		sc_all_health();
		sc_bad_id();
		sc_masked();
		give_verdict();
	end
endmodule // ftr_report_tail_tb
